// [rtcs_pkg.sv]
package rtcs_pkg;
	// ==========================================
	// Register indices (byte address is index times four)
	localparam logic [3:0] IDX_SNAP_B0 = 4'h0;
	localparam logic [3:0] IDX_SNAP_B3 = 4'h3;
	localparam logic [3:0] IDX_CTRL = 4'h4;
	localparam logic [3:0] IDX_OSC_CFG = 4'h6;
	localparam logic [3:0] IDX_PIN_KEY = 4'h7;
	localparam logic [3:0] IDX_MATCH_B0 = 4'h8;
	localparam logic [3:0] IDX_MATCH_B3 = 4'hb;
	localparam logic [3:0] IDX_IRQ_STAT = 4'hc;
	localparam logic [3:0] IDX_IRQ_MASK = 4'hd;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_W = 6;
	// ==========================================
	// Field positions
	localparam int CFG_STEP_EN_BIT = 7;
	localparam int CFG_SETTLED_BIT = 6;
	localparam int CFG_CAP_HI = 3;
	localparam int CTRL_SNAP_BIT = 0;
	localparam int CTRL_LOAD_BIT = 1;
	localparam int CTRL_FLAG_BIT = 2;
	localparam int CTRL_MATCH_EN_BIT = 3;
	localparam int CTRL_RUN_BIT = 4;
	localparam int IRQ_MATCH_BIT = 0;
	localparam int IRQ_SETTLE_BIT = 1;
	localparam int IRQ_SNAP_BIT = 2;
	localparam int IRQ_LOAD_BIT = 3;
	localparam int IRQ_W = 4;
	// ==========================================
	// Keys, reset values, timing
	localparam logic [7:0] PIN_KEY_SHORT = 8'he7;
	localparam logic [7:0] PIN_KEY_NORMAL = 8'h67;
	localparam logic [3:0] CAP_TARGET_RST = 4'h0;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam int CLK_HZ = 50000000;
	localparam int STEP_PERIOD_US = 10;
	localparam int STEP_CYCLES = CLK_HZ / 1000000 * STEP_PERIOD_US;
	localparam int STEP_CNT_W = 9;

	typedef enum logic [1:0] {
		XS_IDLE = 2'b00,
		XS_SNAP = 2'b01,
		XS_LOAD = 2'b10
	} rtcs_xfer_t;
endpackage

// [rtcs_top.sv]
`timescale 1ns/1ps
module rtcs_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rtcs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic osc_pins_shorted,
	output logic [3:0] load_cap_applied,
	output logic [31:0] timer_value,
	output logic wake_match_flag,
	output logic irq
);
	// ==========================================
	// Bus decode
	wire logic [3:0] idx = paddr[rtcs_pkg::ADDR_W-1:rtcs_pkg::ADDR_LSB];
	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite && pstrb[0];
	wire logic rd = acc && !pwrite;
	wire logic [7:0] wb = pwdata[7:0];
	wire logic hit_snap = idx <= rtcs_pkg::IDX_SNAP_B3;
	wire logic hit_match = idx >= rtcs_pkg::IDX_MATCH_B0 && idx <= rtcs_pkg::IDX_MATCH_B3;
	wire logic hit_ctrl = idx == rtcs_pkg::IDX_CTRL;
	wire logic hit_cfg = idx == rtcs_pkg::IDX_OSC_CFG;
	wire logic hit_key = idx == rtcs_pkg::IDX_PIN_KEY;
	wire logic hit_stat = idx == rtcs_pkg::IDX_IRQ_STAT;
	wire logic hit_mask = idx == rtcs_pkg::IDX_IRQ_MASK;
	wire logic mapped = hit_snap || hit_match || hit_ctrl || hit_cfg || hit_key
		|| hit_stat || hit_mask;
	wire logic [1:0] lane = idx[1:0];

	function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] b,
		input logic [7:0] v);
		logic [31:0] r;
		r = w;
		r[b*8 +: 8] = v;
		return r;
	endfunction

	// ==========================================
	// Registers
	logic [31:0] snap_r, snap_nxt;
	logic [31:0] match_r;
	logic [31:0] timer_r, timer_nxt;
	logic step_en_r;
	logic [3:0] cap_target_r;
	logic [3:0] cap_applied_r;
	logic [7:0] pin_key_r;
	logic run_r, match_en_r, auto_rst_r, flag_r;
	logic snap_req_r, load_req_r;
	rtcs_pkg::rtcs_xfer_t xfer_r, xfer_nxt;
	logic [rtcs_pkg::IRQ_W-1:0] stat_r, mask_r, ev;
	logic [rtcs_pkg::STEP_CNT_W-1:0] step_cnt_r;
	logic [31:0] rdata_nxt;

	wire logic settled = cap_applied_r == cap_target_r;
	wire logic step_tick = step_cnt_r == rtcs_pkg::STEP_CNT_W'(rtcs_pkg::STEP_CYCLES - 1);
	wire logic match_hit = match_en_r && timer_r == match_r;
	wire logic settled_rise;
	logic settled_prev_r;
	assign settled_rise = settled && !settled_prev_r;

	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign osc_pins_shorted = pin_key_r == rtcs_pkg::PIN_KEY_SHORT;
	assign load_cap_applied = cap_applied_r;
	assign timer_value = timer_r;
	assign wake_match_flag = flag_r;
	assign irq = |(stat_r & mask_r);

	// ==========================================
	// Read mux
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hit_snap) begin
			rdata_nxt[7:0] = snap_r[lane*8 +: 8];
		end else if (hit_match) begin
			rdata_nxt[7:0] = match_r[lane*8 +: 8];
		end else if (hit_cfg) begin
			rdata_nxt[rtcs_pkg::CFG_STEP_EN_BIT] = step_en_r;
			rdata_nxt[rtcs_pkg::CFG_SETTLED_BIT] = settled;
			rdata_nxt[rtcs_pkg::CFG_CAP_HI:0] = cap_target_r;
		end else if (hit_ctrl) begin
			rdata_nxt[rtcs_pkg::CTRL_SNAP_BIT] = snap_req_r;
			rdata_nxt[rtcs_pkg::CTRL_LOAD_BIT] = load_req_r;
			rdata_nxt[rtcs_pkg::CTRL_FLAG_BIT] = flag_r;
			rdata_nxt[rtcs_pkg::CTRL_MATCH_EN_BIT] = match_en_r;
			rdata_nxt[rtcs_pkg::CTRL_RUN_BIT] = run_r;
		end else if (hit_stat) begin
			rdata_nxt[rtcs_pkg::IRQ_W-1:0] = stat_r;
		end else if (hit_mask) begin
			rdata_nxt[rtcs_pkg::IRQ_W-1:0] = mask_r;
		end
	end

	// ==========================================
	// Transfer sequencer and timer
	always_comb begin
		xfer_nxt = xfer_r;
		case (xfer_r)
			rtcs_pkg::XS_IDLE: begin
				if (load_req_r) begin
					xfer_nxt = rtcs_pkg::XS_LOAD;
				end else if (snap_req_r) begin
					xfer_nxt = rtcs_pkg::XS_SNAP;
				end
			end
			rtcs_pkg::XS_SNAP: xfer_nxt = rtcs_pkg::XS_IDLE;
			rtcs_pkg::XS_LOAD: xfer_nxt = rtcs_pkg::XS_IDLE;
			default: xfer_nxt = rtcs_pkg::XS_IDLE;
		endcase
	end

	always_comb begin
		timer_nxt = timer_r;
		if (xfer_r == rtcs_pkg::XS_LOAD) begin
			timer_nxt = snap_r;
		end else if (match_hit && auto_rst_r) begin
			timer_nxt = 32'h0000_0000;
		end else if (run_r) begin
			timer_nxt = timer_r + 32'h0000_0001;
		end
	end

	always_comb begin
		snap_nxt = snap_r;
		if (xfer_r == rtcs_pkg::XS_SNAP) begin
			snap_nxt = timer_r;
		end else if (wr && hit_snap) begin
			snap_nxt = put_byte(snap_r, lane, wb);
		end
	end

	always_comb begin
		ev = '0;
		ev[rtcs_pkg::IRQ_MATCH_BIT] = match_hit;
		ev[rtcs_pkg::IRQ_SETTLE_BIT] = settled_rise && step_en_r;
		ev[rtcs_pkg::IRQ_SNAP_BIT] = xfer_r == rtcs_pkg::XS_SNAP;
		ev[rtcs_pkg::IRQ_LOAD_BIT] = xfer_r == rtcs_pkg::XS_LOAD;
	end

	// ==========================================
	// Next values
	function automatic logic [3:0] step_toward(input logic [3:0] cur, input logic [3:0] tgt);
		return (cur < tgt) ? cur + 4'h1 : cur - 4'h1;
	endfunction

	wire logic ctrl_wr = wr && hit_ctrl;
	wire logic cfg_wr = wr && hit_cfg;
	wire logic key_legal = wb == rtcs_pkg::PIN_KEY_SHORT || wb == rtcs_pkg::PIN_KEY_NORMAL;
	wire logic key_wr = wr && hit_key && key_legal;
	wire logic prdata_en = psel && !penable && !pwrite;
	wire logic snap_done = xfer_r == rtcs_pkg::XS_SNAP;
	wire logic load_done = xfer_r == rtcs_pkg::XS_LOAD;
	wire logic [rtcs_pkg::STEP_CNT_W-1:0] step_cnt_nxt = step_tick ? '0 : step_cnt_r + 1'b1;
	// Stepping off: applied follows target at once
	wire logic [3:0] cap_applied_nxt = !step_en_r ? cap_target_r
		: (step_tick && !settled) ? step_toward(cap_applied_r, cap_target_r)
		: cap_applied_r;
	// Done clears a request; a new write of 1 re-arms it
	wire logic snap_req_nxt = (ctrl_wr && wb[rtcs_pkg::CTRL_SNAP_BIT]) ? 1'b1
		: snap_done ? 1'b0 : snap_req_r;
	wire logic load_req_nxt = (ctrl_wr && wb[rtcs_pkg::CTRL_LOAD_BIT]) ? 1'b1
		: load_done ? 1'b0 : load_req_r;
	// Disabling the alarm drops the flag; a match in the same cycle wins
	wire logic flag_nxt = match_hit ? 1'b1
		: (ctrl_wr && !wb[rtcs_pkg::CTRL_MATCH_EN_BIT]) ? 1'b0 : flag_r;
	// Read clears only the bits it returned; newer events survive
	wire logic [rtcs_pkg::IRQ_W-1:0] stat_clr = (rd && hit_stat) ? prdata[rtcs_pkg::IRQ_W-1:0]
		: '0;
	wire logic [rtcs_pkg::IRQ_W-1:0] stat_nxt = (stat_r & ~stat_clr) | ev;

	// ==========================================
	// Flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (prdata_en) begin
			prdata <= rdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_r <= 32'h0000_0000;
		end else begin
			snap_r <= snap_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_r <= 32'h0000_0000;
		end else begin
			timer_r <= timer_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_r <= rtcs_pkg::XS_IDLE;
		end else begin
			xfer_r <= xfer_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_r <= 32'h0000_0000;
		end else if (wr && hit_match) begin
			match_r <= put_byte(match_r, lane, wb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_en_r <= 1'b0;
		end else if (cfg_wr) begin
			step_en_r <= wb[rtcs_pkg::CFG_STEP_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_target_r <= rtcs_pkg::CAP_TARGET_RST;
		end else if (cfg_wr) begin
			cap_target_r <= wb[rtcs_pkg::CFG_CAP_HI:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_key_r <= rtcs_pkg::PIN_KEY_NORMAL;
		end else if (key_wr) begin
			pin_key_r <= wb;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_applied_r <= rtcs_pkg::CAP_TARGET_RST;
		end else begin
			cap_applied_r <= cap_applied_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt_r <= '0;
		end else begin
			step_cnt_r <= step_cnt_nxt;
		end
	end

	// Settled after reset, so no false rise follows it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settled_prev_r <= 1'b1;
		end else begin
			settled_prev_r <= settled;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= rtcs_pkg::CTRL_RST[rtcs_pkg::CTRL_RUN_BIT];
		end else if (ctrl_wr) begin
			run_r <= wb[rtcs_pkg::CTRL_RUN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_en_r <= rtcs_pkg::CTRL_RST[rtcs_pkg::CTRL_MATCH_EN_BIT];
		end else if (ctrl_wr) begin
			match_en_r <= wb[rtcs_pkg::CTRL_MATCH_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_rst_r <= rtcs_pkg::CTRL_RST[rtcs_pkg::CTRL_FLAG_BIT];
		end else if (ctrl_wr) begin
			auto_rst_r <= wb[rtcs_pkg::CTRL_FLAG_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_req_r <= rtcs_pkg::CTRL_RST[rtcs_pkg::CTRL_SNAP_BIT];
		end else begin
			snap_req_r <= snap_req_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_req_r <= rtcs_pkg::CTRL_RST[rtcs_pkg::CTRL_LOAD_BIT];
		end else begin
			load_req_r <= load_req_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= '0;
		end else if (wr && hit_mask) begin
			mask_r <= wb[rtcs_pkg::IRQ_W-1:0];
		end
	end
endmodule // rtcs_top

// [rtcs_top_props.sv]
`timescale 1ns/1ps
module rtcs_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rtcs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_pins_shorted,
	input wire logic [3:0] load_cap_applied,
	input wire logic wake_match_flag
);
	// ==========================================
	// Bus decode and properties
	wire logic acc = psel && penable;
	wire logic [3:0] idx = paddr[5:2];
	wire logic wr_ok = acc && pwrite && pstrb[0];
	wire logic cfg_rd = acc && !pwrite && idx == 4'h6;
	wire logic key_wr = wr_ok && idx == 4'h7;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_key(logic [7:0] v);
		wr_ok && idx == 4'h7 && pwdata[7:0] == v;
	endsequence
	a_key_short: assert property (s_key(8'he7) |=> osc_pins_shorted)
		else $error("pins not shorted");
	a_key_normal: assert property (s_key(8'h67) |=> !osc_pins_shorted)
		else $error("pins still shorted");
	a_short_cause: assert property ($changed(osc_pins_shorted) |-> $past(key_wr))
		else $error("pin state moved without key write");
	a_cfg_zero: assert property (cfg_rd |-> prdata[31:8] == 24'h0 && prdata[5:4] == 2'h0)
		else $error("config unused bits set");
	a_cap_follow: assert property (cfg_rd && !prdata[7] |-> load_cap_applied == prdata[3:0])
		else $error("applied cap differs from target");
	a_flag_off: assert property (wr_ok && idx == 4'h4 && !pwdata[3] |=> !wake_match_flag)
		else $error("flag stays with alarm off");
	a_bad_index: assert property (acc && (idx == 4'h5 || idx > 4'hd) |-> pslverr)
		else $error("no error on unmapped index");
	a_good_index: assert property (acc && idx < 4'h5 |-> pready && !pslverr)
		else $error("mapped access refused");
endmodule // rtcs_chk
bind rtcs_top rtcs_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .osc_pins_shorted, .load_cap_applied, .wake_match_flag);

// [rtcs_xtal_model.sv]
`timescale 1ns/1ps
module rtcs_xtal_model (
	input wire logic shorted,
	output logic pin_a,
	output logic pin_b
);
	// ==========================================
	// Crystal swing, pins tied when shorted
	initial pin_a = 1'b0;
	always #15259 pin_a = ~pin_a;
	assign pin_b = shorted ? pin_a : ~pin_a;
endmodule // rtcs_xtal_model

// [tb_rtcs_top.sv]
`timescale 1ns/1ps
module tb_rtcs_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [5:0] paddr = 6'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, tv, r;
	logic [3:0] cap;
	logic pready, pslverr, shorted, flag, irq, xa, xb, e;
	int fail_count = 0;
	int check_count = 0;
	int n;
	always #10 pclk = ~pclk;
	rtcs_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .osc_pins_shorted(shorted), .load_cap_applied(cap),
		.timer_value(tv), .wake_match_flag(flag), .irq);
	rtcs_xtal_model xtal_u (.shorted, .pin_a(xa), .pin_b(xb));
	// ==========================================
	// Bus and check tasks
	task give_verdict;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task tmo(input logic ok);
		check_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t wait ran out", $time);
			give_verdict();
		end
	endtask
	task apb(input logic w, input logic [3:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		tmo(pready === 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [3:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask
	task rd(input logic [3:0] i, input logic [31:0] x);
		apb(1'b0, i, 8'h0);
		chk(r, x);
	endtask
	task settle;
		repeat (3) @(negedge pclk);
	endtask
	task wait_cap(input logic [3:0] v, input int m);
		n = 0;
		while (cap !== v && n < m) begin
			@(negedge pclk);
			n++;
		end
		tmo(cap === v);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 12; i++) if (i < 4 || i > 7) rd(i[3:0], 32'h0);
		rd(4'h6, 32'h40);
		chk(shorted, 1'b0);
		wr(4'h7, 8'he7);
		settle();
		chk(shorted, 1'b1);
		chk(xb, xa);
		wr(4'h7, 8'h12);
		settle();
		chk(shorted, 1'b1);
		wr(4'h7, 8'h67);
		settle();
		chk(shorted, 1'b0);
		wr(4'h6, 8'h3f);
		rd(4'h6, 32'h4f);
		wr(4'h6, 8'h80);
		rd(4'h6, 32'h80);
		wait_cap(4'he, 600);
		wait_cap(4'h0, 8000);
		rd(4'h6, 32'hc0);
		chk(irq, 1'b0);
		wr(4'hd, 8'h02);
		settle();
		chk(irq, 1'b1);
		rd(4'hc, 32'h02);
		settle();
		chk(irq, 1'b0);
		for (int i = 0; i < 4; i++) wr(i[3:0], 8'(8'h11 * (i + 1)));
		wr(4'h4, 8'h02);
		settle();
		chk(tv, 32'h44332211);
		rd(4'h4, 32'h0);
		wr(4'h0, 8'h00);
		settle();
		chk(tv, 32'h44332211);
		wr(4'h4, 8'h01);
		settle();
		rd(4'h4, 32'h0);
		rd(4'h0, 32'h11);
		for (int i = 8; i < 12; i++) wr(i[3:0], 8'(8'h11 * (i - 7)));
		wr(4'h8, 8'h15);
		rd(4'h8, 32'h15);
		rd(4'hb, 32'h44);
		wr(4'h4, 8'h18);
		n = 0;
		while (flag !== 1'b1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		tmo(flag === 1'b1);
		apb(1'b0, 4'h4, 8'h0);
		chk(r[2], 1'b1);
		wr(4'h4, 8'h04);
		settle();
		chk(flag, 1'b0);
		apb(1'b0, 4'h4, 8'h0);
		chk(r[2], 1'b0);
		wr(4'h4, 8'h02);
		settle();
		chk(tv, 32'h44332211);
		wr(4'h4, 8'h1c);
		n = 0;
		while (flag !== 1'b1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		tmo(flag === 1'b1);
		chk(tv, 32'h0);
		wr(4'h4, 8'h00);
		pstrb <= 4'h0;
		wr(4'h9, 8'h77);
		pstrb <= 4'hf;
		rd(4'h9, 32'h22);
		rd(4'hc, 32'h0d);
		wr(4'h5, 8'hff);
		apb(1'b0, 4'he, 8'h0);
		chk(e, 1'b1);
		chk(r, 32'h0);
		give_verdict();
	end
endmodule // tb_rtcs_top
